/* File: rtl/e1j_clkdiv.sv */
// Smoothed read clock divider with selectable divide ratio
`timescale 1ns/1ps
module e1j_clkdiv #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic run,
    input e1j_pkg::e1j_div_type div_sel,
    // Outputs
    output logic tick,
    output logic clk_level
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] ratio;

    always_comb begin
        unique case (div_sel)
            e1j_pkg::DIV_FAST: ratio = WIDTH'(e1j_pkg::DIV_BY_FAST);
            e1j_pkg::DIV_SLOW: ratio = WIDTH'(e1j_pkg::DIV_BY_SLOW);
            e1j_pkg::DIV_NOM: ratio = WIDTH'(e1j_pkg::DIV_BY_NOM);
            default: ratio = WIDTH'(e1j_pkg::DIV_BY_NOM);
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= '0;
        end else if (!run || count_reg >= ratio - WIDTH'(1)) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + WIDTH'(1);
        end
    end

    assign tick = run && (count_reg >= ratio - WIDTH'(1));
    // Roughly even duty whatever the ratio
    assign clk_level = run && (count_reg < (ratio >> 1));
endmodule // e1j_clkdiv

/* File: rtl/e1j_pkg.sv */
// Constants and types shared by the E1 line interface control block
package e1j_pkg;
    // Register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h18;
    localparam logic [7:0] RXI_ADDR = 8'h1c;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h20;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h24;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // Field positions in the receive information register
    localparam int RXI_TRIP_BIT = 5;
    localparam int RXI_LOSS_BIT = 0;
    // Oversampling and read clock division
    localparam int OVERSAMPLE = 16;
    localparam logic [4:0] DIV_BY_NOM = 5'h10;
    localparam logic [4:0] DIV_BY_FAST = 5'h0f;
    localparam logic [4:0] DIV_BY_SLOW = 5'h11;
    localparam logic [3:0] SAMPLE_CENTER = 4'h8;
    localparam logic [3:0] SHORT_HIGH = 4'h6;
    // Jitter attenuator depths and limits, in bits
    localparam int FIFO_DEEP = 128;
    localparam int FIFO_SHALLOW = 32;
    localparam int JIT_LIMIT_DEEP = 120;
    localparam int JIT_LIMIT_SHALLOW = 28;
    localparam logic [7:0] HIGH_DEEP = 8'(FIFO_DEEP / 2 + JIT_LIMIT_DEEP / 2);
    localparam logic [7:0] LOW_DEEP = 8'(FIFO_DEEP / 2 - JIT_LIMIT_DEEP / 2);
    localparam logic [7:0] HIGH_SHALLOW =
        8'(FIFO_SHALLOW / 2 + JIT_LIMIT_SHALLOW / 2);
    localparam logic [7:0] LOW_SHALLOW =
        8'(FIFO_SHALLOW / 2 - JIT_LIMIT_SHALLOW / 2);
    // Carrier loss after this many bit times without a mark
    localparam int LOSS_BITS = 255;
    localparam logic [11:0] LOSS_SAMPLES = 12'(LOSS_BITS * OVERSAMPLE);
    // Transmit mark length in samples (half a bit)
    localparam logic [3:0] TX_MARK_SAMPLES = 4'h8;

    typedef enum logic [2:0] {
        DIV_NOM = 3'b001,
        DIV_FAST = 3'b010,
        DIV_SLOW = 3'b100
    } e1j_div_type;

    typedef enum logic [5:0] {
        SH_75_NORM = 6'b000001,
        SH_120_NORM = 6'b000010,
        SH_75_PROT = 6'b000100,
        SH_120_PROT = 6'b001000,
        SH_75_HRL = 6'b010000,
        SH_120_HRL = 6'b100000
    } e1j_shape_type;

    typedef struct packed {
        logic [2:0] build_out_sel;
        logic eq_gain_limit;
        logic jitter_atten_side;
        logic jitter_buf_depth;
        logic jitter_atten_disable;
        logic tx_power_down;
    } e1j_ctrl_type;

    typedef struct packed {
        logic limit_trip;
        logic carrier_loss;
    } e1j_irq_type;
endpackage

/* File: rtl/e1j_top.sv */
// E1 line interface: control register, clock recovery, jitter attenuator
//
// How it works
// - Control bits 7..5 choose transmit waveshape
// - Decode build-out code into waveshape select
// - Bit 4 sets equalizer gain limit
// - Bit 3 puts attenuator on receive/transmit
// - Bit 2 picks 128 or 32 bit depth
// - Bit 1 set bypasses the attenuator
// - Bit 0 powers down and floats transmitter
// - Oversample line sixteen times, recover clock/data
// - No carrier: flag it, use master clock
// - Attenuator on receive gives even duty clock
// - Smoothed clock reads data from the FIFO
// - Gapped transmit clock still gives smooth output
// - Near limit, divide by 15 or 17
// - Odd divide sets limit trip status bit
`timescale 1ns/1ps
module e1j_top #(
    parameter int FIFO_MAX = 128
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Receive line, sampled at the oversample rate
    input wire logic rx_line_pos,
    input wire logic rx_line_neg,
    input wire logic mclk_in,
    // Transmit clock and data from the framer
    input wire logic tx_clock_in,
    input wire logic tx_data_in,
    // Receive side toward the framer
    output logic recovered_clock_out,
    output logic rx_data_out,
    output logic rx_bit_strobe,
    output logic rx_carrier_loss,
    // Transmit line drivers
    output logic tx_line_pos_o,
    output logic tx_line_neg_o,
    output logic tx_line_oe_n,
    output logic tx_clock,
    // Analog settings
    output e1j_pkg::e1j_shape_type line_shape,
    output logic eq_gain_limit,
    // Interrupt
    output logic irq
);
    e1j_pkg::e1j_ctrl_type ctrl_reg;
    e1j_pkg::e1j_irq_type stat_reg;
    e1j_pkg::e1j_irq_type mask_reg;
    e1j_pkg::e1j_irq_type stat_set;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic addr_ok;
    logic rd_take;
    logic [31:0] rd_value;
    logic [7:0] ctrl_now;

    // AHB-Lite: zero wait state, OKAY always
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = hsel && htrans[1] && hready;
    assign rd_take = addr_ok && !hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    // A control register write in its data phase is forwarded to a following read
    assign ctrl_now = (wr_pend_reg && wr_addr_reg == e1j_pkg::CTRL_ADDR) ?
        hwdata[7:0] : ctrl_reg;

    logic fifo_trip;

    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (haddr[7:0])
            e1j_pkg::CTRL_ADDR: rd_value[7:0] = ctrl_now;
            e1j_pkg::RXI_ADDR: begin
                rd_value[e1j_pkg::RXI_TRIP_BIT] = fifo_trip;
                rd_value[e1j_pkg::RXI_LOSS_BIT] = rx_carrier_loss;
            end
            e1j_pkg::IRQ_STAT_ADDR: rd_value[1:0] = stat_reg;
            e1j_pkg::IRQ_MASK_ADDR: rd_value[1:0] = mask_reg;
            default: rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata <= rd_value;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= e1j_pkg::CTRL_RESET;
            mask_reg <= e1j_pkg::IRQ_RESET;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == e1j_pkg::CTRL_ADDR) begin
                ctrl_reg <= hwdata[7:0];
            end
            if (wr_addr_reg == e1j_pkg::IRQ_MASK_ADDR) begin
                mask_reg <= hwdata[1:0];
            end
        end
    end

    // Read clears the status, a new event in the same cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_reg <= e1j_pkg::IRQ_RESET;
        end else if (rd_take && haddr[7:0] == e1j_pkg::IRQ_STAT_ADDR) begin
            stat_reg <= stat_set;
        end else begin
            stat_reg <= stat_reg | stat_set;
        end
    end

    assign irq = |(stat_reg & mask_reg);

    always_comb begin
        unique case (ctrl_reg.build_out_sel)
            3'b000: line_shape = e1j_pkg::SH_75_NORM;
            3'b001: line_shape = e1j_pkg::SH_120_NORM;
            3'b010: line_shape = e1j_pkg::SH_75_PROT;
            3'b011: line_shape = e1j_pkg::SH_120_PROT;
            3'b100: line_shape = e1j_pkg::SH_75_HRL;
            3'b110: line_shape = e1j_pkg::SH_75_HRL;
            3'b101: line_shape = e1j_pkg::SH_120_HRL;
            default: line_shape = e1j_pkg::SH_75_NORM;
        endcase
    end

    assign eq_gain_limit = ctrl_reg.eq_gain_limit;

    // Clock and data recovery
    logic samp_prev_reg;
    logic mark_rise;
    logic [3:0] phase_reg;
    logic mark_seen_reg;
    logic rec_strobe;
    logic [11:0] quiet_reg;

    assign mark_rise = (rx_line_pos || rx_line_neg) && !samp_prev_reg;
    assign rec_strobe = (phase_reg == e1j_pkg::SAMPLE_CENTER);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_prev_reg <= 1'b0;
            phase_reg <= 4'h0;
        end else begin
            samp_prev_reg <= rx_line_pos || rx_line_neg;
            phase_reg <= mark_rise ? 4'h1 : phase_reg + 4'h1;
        end
    end

    // Mark seen during the bit; a new mark wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mark_seen_reg <= 1'b0;
        end else if (mark_rise) begin
            mark_seen_reg <= 1'b1;
        end else if (rec_strobe) begin
            mark_seen_reg <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_reg <= e1j_pkg::LOSS_SAMPLES;
        end else if (mark_rise) begin
            quiet_reg <= 12'h000;
        end else if (quiet_reg != e1j_pkg::LOSS_SAMPLES) begin
            quiet_reg <= quiet_reg + 12'h001;
        end
    end

    // Starts asserted: no line has been seen out of reset
    assign rx_carrier_loss = (quiet_reg == e1j_pkg::LOSS_SAMPLES);

    // Transmit clock edge detect
    logic tx_clk_prev_reg;
    logic tx_in_rise;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_clk_prev_reg <= 1'b0;
        end else begin
            tx_clk_prev_reg <= tx_clock_in;
        end
    end

    assign tx_in_rise = tx_clock_in && !tx_clk_prev_reg;

    // Jitter attenuator FIFO
    logic ja_on;
    logic ja_rx;
    logic [7:0] depth;
    logic [7:0] fill_reg;
    logic [6:0] wr_ptr_reg;
    logic [6:0] rd_ptr_reg;
    logic [6:0] ptr_mask;
    logic mem [FIFO_MAX];
    logic fifo_wr;
    logic fifo_wdata;
    logic fifo_rd;
    logic ja_bit_reg;
    logic [2:0] cfg_prev_reg;
    logic cfg_change;
    logic [7:0] high_lim;
    logic [7:0] low_lim;
    logic smooth_level;
    e1j_pkg::e1j_div_type div_sel_reg;

    assign ja_on = !ctrl_reg.jitter_atten_disable;
    assign ja_rx = !ctrl_reg.jitter_atten_side;
    assign depth = ctrl_reg.jitter_buf_depth ? 8'(e1j_pkg::FIFO_SHALLOW) :
        8'(e1j_pkg::FIFO_DEEP);
    assign ptr_mask = 7'(depth - 8'h01);
    assign high_lim = ctrl_reg.jitter_buf_depth ? e1j_pkg::HIGH_SHALLOW :
        e1j_pkg::HIGH_DEEP;
    assign low_lim = ctrl_reg.jitter_buf_depth ? e1j_pkg::LOW_SHALLOW :
        e1j_pkg::LOW_DEEP;
    // a gapped transmit clock only writes, never reads
    assign fifo_wr = ja_on && (ja_rx ? rec_strobe : tx_in_rise);
    assign fifo_wdata = ja_rx ? mark_seen_reg : tx_data_in;
    assign cfg_change = cfg_prev_reg != {ctrl_reg.jitter_atten_side,
        ctrl_reg.jitter_buf_depth, ctrl_reg.jitter_atten_disable};

    e1j_clkdiv #(
        .WIDTH(5)
    ) u_read_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(ja_on),
        .div_sel(div_sel_reg),
        .tick(fifo_rd),
        .clk_level(smooth_level)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_prev_reg <= 3'h0;
        end else begin
            cfg_prev_reg <= {ctrl_reg.jitter_atten_side,
                ctrl_reg.jitter_buf_depth, ctrl_reg.jitter_atten_disable};
        end
    end

    // A new setting recentres the FIFO; old contents are stale anyway
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_reg <= 7'h00;
            rd_ptr_reg <= 7'h00;
            fill_reg <= 8'h00;
        end else if (cfg_change) begin
            wr_ptr_reg <= 7'(depth >> 1);
            rd_ptr_reg <= 7'h00;
            fill_reg <= depth >> 1;
        end else begin
            // Overflow drops the bit, underflow skips the read
            if (fifo_wr && fill_reg < depth) begin
                wr_ptr_reg <= (wr_ptr_reg + 7'h01) & ptr_mask;
            end
            if (fifo_rd && fill_reg != 8'h00) begin
                rd_ptr_reg <= (rd_ptr_reg + 7'h01) & ptr_mask;
            end
            fill_reg <= fill_reg + 8'(fifo_wr && fill_reg < depth) -
                8'(fifo_rd && fill_reg != 8'h00);
        end
    end

    always_ff @(posedge hclk) begin
        if (fifo_wr && fill_reg < depth) begin
            mem[wr_ptr_reg] <= fifo_wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ja_bit_reg <= 1'b0;
        end else if (fifo_rd && fill_reg != 8'h00) begin
            ja_bit_reg <= mem[rd_ptr_reg];
        end
    end

    // divide ratio follows the fill level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_sel_reg <= e1j_pkg::DIV_NOM;
        end else if (!ja_on) begin
            div_sel_reg <= e1j_pkg::DIV_NOM;
        end else if (fill_reg >= high_lim) begin
            div_sel_reg <= e1j_pkg::DIV_FAST;
        end else if (fill_reg <= low_lim) begin
            div_sel_reg <= e1j_pkg::DIV_SLOW;
        end else begin
            div_sel_reg <= e1j_pkg::DIV_NOM;
        end
    end

    assign fifo_trip = (div_sel_reg != e1j_pkg::DIV_NOM);
    assign stat_set = '{limit_trip: fifo_trip,
        carrier_loss: rx_carrier_loss};

    // Receive outputs toward the framer
    logic rx_via_ja;

    assign rx_via_ja = ja_on && ja_rx;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            recovered_clock_out <= 1'b0;
            rx_data_out <= 1'b0;
            rx_bit_strobe <= 1'b0;
        end else begin
            if (rx_carrier_loss) begin
                recovered_clock_out <= mclk_in;
            end else if (rx_via_ja) begin
                recovered_clock_out <= smooth_level;
            end else begin
                recovered_clock_out <= phase_reg < e1j_pkg::SHORT_HIGH;
            end
            rx_bit_strobe <= rx_via_ja ? fifo_rd : rec_strobe;
            if (rx_via_ja ? fifo_rd : rec_strobe) begin
                rx_data_out <= rx_via_ja ? ja_bit_reg : mark_seen_reg;
            end
        end
    end

    // Transmit AMI encoder
    logic tx_via_ja;
    logic tx_strobe;
    logic tx_bit;
    logic tx_polarity_reg;
    logic [3:0] tx_mark_reg;
    logic tx_mark_neg_reg;

    assign tx_via_ja = ja_on && !ja_rx;
    assign tx_strobe = tx_via_ja ? fifo_rd : tx_in_rise;
    assign tx_bit = tx_via_ja ? ja_bit_reg : tx_data_in;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_polarity_reg <= 1'b0;
            tx_mark_reg <= 4'h0;
            tx_mark_neg_reg <= 1'b0;
        end else if (tx_strobe && tx_bit) begin
            tx_polarity_reg <= !tx_polarity_reg;
            tx_mark_neg_reg <= tx_polarity_reg;
            tx_mark_reg <= e1j_pkg::TX_MARK_SAMPLES;
        end else if (tx_mark_reg != 4'h0) begin
            tx_mark_reg <= tx_mark_reg - 4'h1;
        end
    end

    // power down floats both line outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_line_pos_o <= 1'b0;
            tx_line_neg_o <= 1'b0;
            tx_line_oe_n <= 1'b1;
            tx_clock <= 1'b0;
        end else begin
            tx_line_oe_n <= ctrl_reg.tx_power_down;
            tx_line_pos_o <= !ctrl_reg.tx_power_down &&
                tx_mark_reg != 4'h0 && !tx_mark_neg_reg;
            tx_line_neg_o <= !ctrl_reg.tx_power_down &&
                tx_mark_reg != 4'h0 && tx_mark_neg_reg;
            tx_clock <= tx_via_ja ? smooth_level : tx_clock_in;
        end
    end

    // Checks
    sequence s_strobe;
        rec_strobe && !mark_rise;
    endsequence
    sequence s_quiet_bit;
        !mark_rise [*8] ##1 !mark_rise [*8];
    endsequence

    chk_shape_decode: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_reg.build_out_sel == 3'b011 |-> line_shape == e1j_pkg::SH_120_PROT)
        else $error("build-out 011 not decoded");
    chk_gain_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        eq_gain_limit == ctrl_reg[4])
        else $error("gain limit not from bit 4");
    chk_power_down: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_reg.tx_power_down |=> tx_line_oe_n && !tx_line_pos_o
        && !tx_line_neg_o)
        else $error("transmitter driving in power down");
    chk_oversample_period: assert property (@(posedge hclk)
        disable iff (!hresetn)
        s_strobe ##1 s_quiet_bit |-> ##0 rec_strobe)
        else $error("free-running bit period not 16 samples");
    chk_loss_source: assert property (@(posedge hclk) disable iff (!hresetn)
        rx_carrier_loss |=> recovered_clock_out == $past(mclk_in))
        else $error("recovered clock not master clock on loss");
    chk_bypass_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        ctrl_reg.jitter_atten_disable |-> !fifo_rd && !fifo_wr)
        else $error("disabled attenuator still active");
    chk_fill_bound: assert property (@(posedge hclk) disable iff (!hresetn)
        fill_reg <= depth || cfg_change || $past(cfg_change))
        else $error("FIFO fill beyond depth");
    chk_fast_div: assert property (@(posedge hclk) disable iff (!hresetn)
        ja_on && fill_reg >= high_lim |=>
        div_sel_reg == e1j_pkg::DIV_FAST || !$past(ja_on, 1) || !ja_on)
        else $error("no divide-15 near overflow");
    chk_trip_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        div_sel_reg != e1j_pkg::DIV_NOM |=> stat_reg.limit_trip)
        else $error("limit trip not raised");
    chk_nominal_back: assert property (@(posedge hclk) disable iff (!hresetn)
        ja_on && fill_reg < high_lim && fill_reg > low_lim |=>
        div_sel_reg == e1j_pkg::DIV_NOM)
        else $error("divider not back to 16");
endmodule // e1j_top

/* File: sim/e1j_line_model.sv */
// Far-end E1 line model: AMI marks for ones and the master reference
`timescale 1ns/1ps
module e1j_line_model (
    // Clock
    input wire logic hclk,
    // Control
    input wire logic send,
    // Line and reference
    output logic rx_line_pos = 1'b0,
    output logic rx_line_neg = 1'b0,
    output logic mclk_in = 1'b0
);
    logic [3:0] phase_reg = 4'h0;
    logic polarity_reg = 1'b0;

    // Reference at one sixteenth of the sample rate
    always_ff @(posedge hclk) begin
        phase_reg <= phase_reg + 4'h1;
        mclk_in <= phase_reg[3];
    end

    // Half-bit marks alternate polarity; an idle line shows no marks
    always_ff @(posedge hclk) begin
        rx_line_pos <= send && !phase_reg[3] && !polarity_reg;
        rx_line_neg <= send && !phase_reg[3] && polarity_reg;
        if (phase_reg == 4'hf) begin
            polarity_reg <= ~polarity_reg;
        end
    end
endmodule // e1j_line_model

/* File: sim/e1j_top_test.sv */
// Self-checking bench for the E1 line interface block
`timescale 1ns/1ps
module e1j_top_test;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic tx_clock_in = 1'b0;
    logic tx_data_in = 1'b0;
    logic send = 1'b0;
    logic [31:0] hrdata, q;
    logic hreadyout, hresp, rx_line_pos, rx_line_neg, mclk_in;
    logic recovered_clock_out, rx_data_out, rx_bit_strobe, rx_carrier_loss;
    logic tx_line_oe_n, eq_gain_limit, irq, tx_line_pos_o, tx_line_neg_o;
    e1j_pkg::e1j_shape_type line_shape;
    int failures = 0;
    int cmp_count = 0;

    always #50 hclk = ~hclk;

    e1j_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_line_pos(rx_line_pos),
        .rx_line_neg(rx_line_neg), .mclk_in(mclk_in),
        .tx_clock_in(tx_clock_in), .tx_data_in(tx_data_in),
        .recovered_clock_out(recovered_clock_out), .rx_data_out(rx_data_out),
        .rx_bit_strobe(rx_bit_strobe), .rx_carrier_loss(rx_carrier_loss),
        .tx_line_pos_o(tx_line_pos_o), .tx_line_neg_o(tx_line_neg_o),
        .tx_line_oe_n(tx_line_oe_n),
        .tx_clock(), .line_shape(line_shape), .eq_gain_limit(eq_gain_limit),
        .irq(irq));

    e1j_line_model line (.hclk(hclk), .send(send), .rx_line_pos(rx_line_pos),
        .rx_line_neg(rx_line_neg), .mclk_in(mclk_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask

    // One single AHB transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 99);
        r = hrdata;
        if (n >= 99) begin
            chk(32'h0, 32'h1);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic t_reset;
        bus(1'b0, e1j_pkg::CTRL_ADDR, 32'h0, q);
        chk(q, 32'h0);
        chk(32'(tx_line_oe_n), 32'h0);
        chk(32'(rx_carrier_loss), 32'h1);
        bus(1'b1, 8'h40, 32'hff, q);
        bus(1'b0, 8'h40, 32'h0, q);
        chk(q, 32'h0);
    endtask

    task automatic t_shapes;
        e1j_pkg::e1j_shape_type shp [8];
        logic [7:0] d;
        shp = '{e1j_pkg::SH_75_NORM, e1j_pkg::SH_120_NORM,
            e1j_pkg::SH_75_PROT, e1j_pkg::SH_120_PROT, e1j_pkg::SH_75_HRL,
            e1j_pkg::SH_120_HRL, e1j_pkg::SH_75_HRL, e1j_pkg::SH_75_NORM};
        for (int c = 0; c < 8; c++) begin
            d = {3'(c), 1'(c), 4'h0};
            bus(1'b1, e1j_pkg::CTRL_ADDR, {24'h0, d}, q);
            bus(1'b0, e1j_pkg::CTRL_ADDR, 32'h0, q);
            chk(q, {24'h0, d});
            chk(32'(line_shape), 32'(shp[c]));
            chk(32'(eq_gain_limit), 32'(d[4]));
        end
    endtask

    task automatic t_power;
        bus(1'b1, e1j_pkg::CTRL_ADDR, 32'h01, q);
        repeat (2) @(posedge hclk);
        chk(32'(tx_line_oe_n), 32'h1);
        bus(1'b1, e1j_pkg::CTRL_ADDR, 32'h00, q);
        repeat (2) @(posedge hclk);
        chk(32'(tx_line_oe_n), 32'h0);
    endtask

    // Marks alternate; attenuator on transmit side trips, then recovers
    task automatic t_tx;
        int p;
        int ng;
        p = 0;
        ng = 0;
        bus(1'b1, e1j_pkg::CTRL_ADDR, 32'h02, q);
        tx_data_in <= 1'b1;
        for (int i = 0; i < 128; i++) begin
            @(posedge hclk);
            tx_clock_in <= i[3];
            if (i >= 64) begin
                p += (tx_line_pos_o === 1'b1);
                ng += (tx_line_neg_o === 1'b1);
            end
        end
        chk(32'(p), 32'd16);
        chk(32'(ng), 32'd16);
        bus(1'b1, e1j_pkg::CTRL_ADDR, 32'h08, q);
        // Writes at twice the read rate; the last value leaves it low
        for (int i = 0; i < 1100; i++) begin
            @(posedge hclk);
            tx_clock_in <= i[2];
        end
        bus(1'b0, e1j_pkg::RXI_ADDR, 32'h0, q);
        chk(32'(q[e1j_pkg::RXI_TRIP_BIT]), 32'h1);
        repeat (300) @(posedge hclk);
        bus(1'b0, e1j_pkg::RXI_ADDR, 32'h0, q);
        chk(32'(q[e1j_pkg::RXI_TRIP_BIT]), 32'h0);
        bus(1'b0, e1j_pkg::IRQ_STAT_ADDR, 32'h0, q);
        chk(q & 32'h2, 32'h2);
    endtask

    // Idle line, carrier returns, idle again; interrupt follows
    task automatic t_carrier;
        logic m;
        int n;
        int hi;
        bus(1'b1, e1j_pkg::IRQ_MASK_ADDR, 32'h1, q);
        @(posedge hclk);
        chk(32'(irq), 32'h1);
        for (int i = 0; i < 32; i++) begin
            @(posedge hclk);
            m = mclk_in;
            #1 chk(32'(recovered_clock_out), 32'(m));
        end
        bus(1'b1, e1j_pkg::CTRL_ADDR, 32'h02, q);
        send <= 1'b1;
        n = 0;
        // Skip a free-running strobe that may come before the first mark
        repeat (2) begin
            do begin
                @(posedge hclk);
                n++;
            end while (rx_bit_strobe !== 1'b1 && n < 64);
        end
        chk(32'(rx_data_out), 32'h1);
        chk(32'(rx_carrier_loss), 32'h0);
        hi = 0;
        for (int i = 0; i < 32; i++) begin
            @(posedge hclk);
            hi += (recovered_clock_out === 1'b1);
        end
        chk(32'(hi), 32'd12);
        bus(1'b1, e1j_pkg::CTRL_ADDR, 32'h00, q);
        repeat (64) @(posedge hclk);
        hi = 0;
        for (int i = 0; i < 32; i++) begin
            @(posedge hclk);
            hi += (recovered_clock_out === 1'b1);
        end
        chk(32'(hi >= 14 && hi <= 18), 32'h1);
        bus(1'b0, e1j_pkg::IRQ_STAT_ADDR, 32'h0, q);
        chk(q & 32'h1, 32'h1);
        bus(1'b0, e1j_pkg::IRQ_STAT_ADDR, 32'h0, q);
        chk(q & 32'h1, 32'h0);
        chk(32'(irq), 32'h0);
        bus(1'b0, e1j_pkg::RXI_ADDR, 32'h0, q);
        chk(q & 32'h1, 32'h0);
        send <= 1'b0;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (rx_carrier_loss !== 1'b1 && n < 4300);
        chk(32'(n >= 4000 && n < 4300), 32'h1);
        @(posedge hclk);
        chk(32'(irq), 32'h1);
    endtask

    initial begin
        #2_000_000;
        failures++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_shapes();
        t_power();
        t_carrier();
        t_tx();
        report_and_stop();
    end
endmodule // e1j_top_test
